// ---- ccdseq_regs.svh ----
`ifndef CCDSEQ_REGS_SVH
`define CCDSEQ_REGS_SVH

// line layout, in reset clock periods counted from the first line pixel
`define CCD_PIX_ACTIVE      12'hd80
`define CCD_PIX_BLACK       12'h004
`define CCD_BLK1_START      12'h00d
`define CCD_IMG_START       12'h011
`define CCD_BLK2_START      12'hd91
`define CCD_GAP_START       12'hd95
`define CCD_WHT_START       12'hd9f
`define CCD_WHT_COUNT       12'h002
`define CCD_LINE_LEN        12'hda1

// least transfer spacing, in reset clock periods
`define CCD_MIN_XFER_PIX    3489

// controller clock and link timing
`define CCD_MCLK_NS         40
`define CCD_PIX_MAX_MHZ     8
`define CCD_PIX_HIGH_MIN_NS 40
`define CCD_TLXL_MIN_NS     50
`define CCD_XLTH_MIN_NS     50
`define CCD_THXH_MAX_NS     50
`define CCD_THWL_MAX_NS     50
`define CCD_TLWH_MAX_NS     50

// least times round up to whole controller cycles
`define CCD_CYC_UP(ns)      (((ns) + `CCD_MCLK_NS - 1) / `CCD_MCLK_NS)
`define CCD_PIX_HIGH_CYC    `CCD_CYC_UP(`CCD_PIX_HIGH_MIN_NS)
`define CCD_TLXL_CYC        `CCD_CYC_UP(`CCD_TLXL_MIN_NS)
`define CCD_XLTH_CYC        `CCD_CYC_UP(`CCD_XLTH_MIN_NS)

// transport period in controller cycles: two reset periods of four cycles
`define CCD_TCK_PERIOD      8
`define CCD_PIX_PERIOD      4

// reset periods of sampling lag between transfer fall and pixel 0
`define CCD_SAMPLE_LAG      2'h3

`endif

// ---- ccdseq_pkg.sv ----
`include "ccdseq_regs.svh"

package ccdseq_pkg;

  typedef enum logic [1:0] {
    KIND_EMPTY,
    KIND_BLACK,
    KIND_IMAGE,
    KIND_WHITE
  } ccdseq_kind_t;

  typedef enum logic [1:0] {
    SAMP_IDLE,
    SAMP_SKIP,
    SAMP_LINE
  } ccdseq_samp_t;

  function automatic ccdseq_kind_t ccdseq_classify(input logic [11:0] pos);
    ccdseq_kind_t k;
    k = KIND_EMPTY;
    if (pos >= `CCD_LINE_LEN) begin
      k = KIND_EMPTY;
    end else if (pos >= `CCD_WHT_START) begin
      k = KIND_WHITE;
    end else if (pos >= `CCD_GAP_START) begin
      k = KIND_EMPTY;
    end else if (pos >= `CCD_BLK2_START) begin
      k = KIND_BLACK;
    end else if (pos >= `CCD_IMG_START) begin
      k = KIND_IMAGE;
    end else if (pos >= `CCD_BLK1_START) begin
      k = KIND_BLACK;
    end
    return k;
  endfunction : ccdseq_classify

  function automatic logic [7:0] ccdseq_sat8(input logic [15:0] v);
    return (v[15:12] != 4'h0) ? 8'hff : v[11:4];
  endfunction : ccdseq_sat8

endpackage : ccdseq_pkg

// ---- ccdseq_link_if.sv ----
interface ccdseq_link_if;
  logic       pixel_reset_clock;
  logic       transport_clock;
  logic       charge_transfer_pulse;
  logic       white_ref_clock;
  logic [7:0] video_output;
  logic       end_of_scan_pulse;

  modport sensor (
    input  pixel_reset_clock,
    input  transport_clock,
    input  charge_transfer_pulse,
    input  white_ref_clock,
    output video_output,
    output end_of_scan_pulse
  );

  modport ctrl (
    output pixel_reset_clock,
    output transport_clock,
    output charge_transfer_pulse,
    output white_ref_clock,
    input  video_output,
    input  end_of_scan_pulse
  );
endinterface : ccdseq_link_if

// ---- ccdseq_sensor.sv ----
`include "ccdseq_regs.svh"

module ccdseq_sensor (
  // link to the clock generator
  ccdseq_link_if.sensor     link,
  // user side
  input  wire logic         rst_n_i,
  input  wire logic [7:0]   illum_i
);

  logic        rst_s1;
  logic        rst_s2;
  logic        xfer_s1;
  logic        xfer_s2;
  logic        xfer_s3;
  logic        tck_s1;
  logic        tck_s2;
  logic        wr_s1;
  logic        wr_s2;
  logic [7:0]  illum_s1;
  logic [7:0]  illum_s2;
  logic [15:0] accum;
  logic [15:0] well;
  logic [7:0]  reg_even;
  logic [7:0]  reg_odd;
  logic [11:0] pos;
  logic [11:0] next_pos;
  logic        wr_seen;
  logic        wr_armed;
  logic        xfer_rise;
  logic        xfer_fall;
  logic [7:0]  next_video;
  ccdseq_pkg::ccdseq_kind_t kind;

  // every pin is sampled on the reset clock; the clock generator keeps
  // all pin edges away from the reset clock rise
  always_ff @(posedge link.pixel_reset_clock) begin
    rst_s1   <= rst_n_i;
    rst_s2   <= rst_s1;
    xfer_s1  <= link.charge_transfer_pulse;
    xfer_s2  <= xfer_s1;
    xfer_s3  <= xfer_s2;
    tck_s1   <= link.transport_clock;
    tck_s2   <= tck_s1;
    wr_s1    <= link.white_ref_clock;
    wr_s2    <= wr_s1;
    illum_s1 <= illum_i;
    illum_s2 <= illum_s1;
  end

  assign xfer_rise = xfer_s2 & ~xfer_s3;
  assign xfer_fall = xfer_s3 & ~xfer_s2;

  // exposure: charge builds between transfers, saturating
  always_ff @(posedge link.pixel_reset_clock) begin
    if (!rst_s2) begin
      accum <= 16'h0000;
    end else if (xfer_s2) begin
      accum <= 16'h0000;
    end else if (accum <= 16'hffff - {8'h00, illum_s2}) begin
      accum <= accum + {8'h00, illum_s2};
    end else begin
      accum <= 16'hffff;
    end
  end

  // storage well while the pulse is high, transport registers on its fall
  always_ff @(posedge link.pixel_reset_clock) begin
    if (!rst_s2) begin
      well     <= 16'h0000;
      reg_even <= 8'h00;
      reg_odd  <= 8'h00;
    end else if (xfer_rise) begin
      well <= accum;
    end else if (xfer_fall) begin
      reg_even <= ccdseq_pkg::ccdseq_sat8(well);
      reg_odd  <= ccdseq_pkg::ccdseq_sat8(well);
    end
  end

  // white injection only when the white reference clock actually pulsed
  always_ff @(posedge link.pixel_reset_clock) begin
    if (!rst_s2) begin
      wr_seen  <= 1'b0;
      wr_armed <= 1'b0;
    end else if (xfer_fall) begin
      wr_armed <= wr_seen | ~wr_s2;
      wr_seen  <= 1'b0;
    end else if (!wr_s2) begin
      wr_seen <= 1'b1;
    end
  end

  // idle position sits at the line length and reads as empty
  always_comb begin
    next_pos = pos;
    if (xfer_fall) begin
      next_pos = 12'h000;
    end else if (pos != `CCD_LINE_LEN) begin
      next_pos = pos + 12'h001;
    end
  end

  always_ff @(posedge link.pixel_reset_clock) begin
    if (!rst_s2) begin
      pos <= `CCD_LINE_LEN;
    end else begin
      pos <= next_pos;
    end
  end

  // one new pixel each reset period; the node is recharged every rising edge
  always_comb begin
    kind       = ccdseq_pkg::ccdseq_classify(next_pos);
    next_video = 8'h00;
    case (kind)
      ccdseq_pkg::KIND_IMAGE: next_video = tck_s2 ? reg_odd : reg_even;
      ccdseq_pkg::KIND_BLACK: next_video = 8'h00;
      ccdseq_pkg::KIND_WHITE: next_video = wr_armed ? 8'hff : 8'h00;
      default:                next_video = 8'h00;
    endcase
  end

  always_ff @(posedge link.pixel_reset_clock) begin
    if (!rst_s2) begin
      link.video_output      <= 8'h00;
      link.end_of_scan_pulse <= 1'b0;
    end else begin
      link.video_output      <= next_video;
      link.end_of_scan_pulse <= wr_armed && (next_pos == `CCD_WHT_START);
    end
  end

endmodule : ccdseq_sensor

// ---- ccdseq_ctrl.sv ----
// Summary of operation
// - sensor delivers 3456 image pixels per line
// - transfer high fills well, fall loads registers
// - two transport registers recombined by clock phase
// - four black pixels at each line end
// - two white pulses injected per scan
// - end of scan coincides with first white
// - each reset period presents one new pixel
// - one pixel sample per reset clock period
// - transport clock is reset clock halved
// - reset clock no faster than 8 MHz
// - transfers spaced at least 3489 reset periods
// - exposure counted in transport periods, then transfer
// - white reference clock at transfer frequency
// - transfer and white at transport submultiples
// - white held high suppresses white and end
// - transport clock keeps running after readout
// - transfer rises within 50 ns of transport rise
// - white low after rise, high after fall
// - transfer falls 50 ns after transport fall
// - 50 ns from transfer fall to transport rise
// - reset clock high at least 40 ns
`include "ccdseq_regs.svh"

module ccdseq_ctrl #(
  parameter int EXPO_TCK = 1800
) (
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  // control
  input  wire logic                     wr_enable_i,
  // link to the sensor
  ccdseq_link_if.ctrl                   link,
  // pixel stream
  output logic                          pix_valid_o,
  output logic [7:0]                    pix_data_o,
  output logic [11:0]                   pix_index_o,
  output ccdseq_pkg::ccdseq_kind_t      pix_kind_o,
  // line events
  output logic                          line_start_o,
  output logic                          line_done_o,
  output logic                          scan_end_o,
  // reference levels for dc restoration
  output logic [7:0]                    black_level_o,
  output logic [7:0]                    white_level_o
);

  // shortest exposure in transport periods, half the reset period count
  localparam int EXPO_MIN = (`CCD_MIN_XFER_PIX + 1) / 2;
  localparam logic [15:0] EXPO_LAST =
    16'((EXPO_TCK < EXPO_MIN) ? (EXPO_MIN - 1) : (EXPO_TCK - 1));
  // transfer falls at this phase, two cycles after transport falls at phase 4
  localparam logic [2:0] XFER_FALL_PH = 3'(4 + `CCD_TLXL_CYC);
  // reset clock high for phases 1 and 2: clear of the transport edges
  localparam logic [1:0] PIX_RISE_PH  = 2'h1;
  localparam logic [1:0] PIX_FALL_PH  = 2'(1 + `CCD_PIX_HIGH_CYC + 1);

  logic [2:0]  phase;
  logic [2:0]  next_phase;
  logic [15:0] expo_cnt;
  logic        slot;
  logic        next_slot;
  logic        xfer_fall_ev;
  logic        capture;
  logic [7:0]  vid_s1;
  logic [7:0]  vid_s2;
  logic        scan_end_s1;
  logic        scan_end_s2;
  logic [1:0]  skip;
  logic [11:0] idx;
  logic [10:0] black_sum;
  logic [7:0]  white_max;
  ccdseq_pkg::ccdseq_samp_t state;
  ccdseq_pkg::ccdseq_kind_t cap_kind;

  // free-running phase: transport period is two reset periods
  assign next_phase   = 3'(phase + 3'h1);
  assign next_slot    = (next_phase == 3'h0) ? (expo_cnt == EXPO_LAST) : slot;
  assign xfer_fall_ev = slot && (next_phase == XFER_FALL_PH);
  assign capture      = (next_phase[1:0] == 2'h0);
  assign cap_kind     = ccdseq_pkg::ccdseq_classify(idx);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      // parked just before a transport rise so the first high is full length
      phase <= 3'h7;
    end else begin
      phase <= next_phase;
    end
  end

  // exposure counter chain in transport periods
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      expo_cnt <= 16'h0000;
      slot     <= 1'b0;
    end else if (next_phase == 3'h0) begin
      expo_cnt <= (expo_cnt == EXPO_LAST) ? 16'h0000 : 16'(expo_cnt + 16'h0001);
      slot     <= next_slot;
    end
  end

  // link clocks; nothing stops, even between lines
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      link.transport_clock       <= 1'b0;
      link.pixel_reset_clock     <= 1'b0;
      link.charge_transfer_pulse <= 1'b0;
      link.white_ref_clock       <= 1'b1;
    end else begin
      link.transport_clock <= ~next_phase[2];
      // reset rises one cycle after transport: never before it
      link.pixel_reset_clock <= (next_phase[1:0] >= PIX_RISE_PH) &&
                                (next_phase[1:0] < PIX_FALL_PH);
      // rises with transport, falls after transport fall; the rest of
      // the period keeps the gap before the next transport rise
      link.charge_transfer_pulse <= next_slot &&
                                    (next_phase < XFER_FALL_PH);
      // one white low pulse per transfer; held high when disabled
      link.white_ref_clock <= !(wr_enable_i &&
                                next_slot &&
                                !next_phase[2]);
    end
  end

  // pins from the sensor pass two flops; sampled a full cycle later
  always_ff @(posedge mclk_i) begin
    vid_s1 <= link.video_output;
    vid_s2 <= vid_s1;
    scan_end_s1 <= link.end_of_scan_pulse;
    scan_end_s2 <= scan_end_s1;
  end

  // pixel position tracking after each transfer fall
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= ccdseq_pkg::SAMP_IDLE;
      skip  <= 2'h0;
      idx   <= 12'h000;
    end else if (xfer_fall_ev) begin
      // a new transfer restarts tracking whatever was in flight
      state <= ccdseq_pkg::SAMP_SKIP;
      skip  <= `CCD_SAMPLE_LAG;
      idx   <= 12'h000;
    end else if (capture) begin
      case (state)
        ccdseq_pkg::SAMP_SKIP: begin
          skip <= 2'(skip - 2'h1);
          if (skip == 2'h1) begin
            state <= ccdseq_pkg::SAMP_LINE;
          end
        end
        ccdseq_pkg::SAMP_LINE: begin
          if (idx == `CCD_LINE_LEN - 12'h001) begin
            state <= ccdseq_pkg::SAMP_IDLE;
          end else begin
            idx <= idx + 12'h001;
          end
        end
        default: begin
          state <= ccdseq_pkg::SAMP_IDLE;
        end
      endcase
    end
  end

  // sample stream out
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pix_valid_o <= 1'b0;
      pix_data_o  <= 8'h00;
      pix_index_o <= 12'h000;
      pix_kind_o  <= ccdseq_pkg::KIND_EMPTY;
      scan_end_o  <= 1'b0;
    end else begin
      pix_valid_o <= capture && !xfer_fall_ev && (state == ccdseq_pkg::SAMP_LINE);
      scan_end_o  <= capture && !xfer_fall_ev && (state == ccdseq_pkg::SAMP_LINE) &&
                     scan_end_s2;
      if (capture && (state == ccdseq_pkg::SAMP_LINE)) begin
        pix_data_o  <= vid_s2;
        pix_index_o <= idx;
        pix_kind_o  <= cap_kind;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      line_start_o <= 1'b0;
      line_done_o  <= 1'b0;
    end else begin
      line_start_o <= xfer_fall_ev;
      line_done_o  <= capture && !xfer_fall_ev && (state == ccdseq_pkg::SAMP_LINE) &&
                      (idx == `CCD_LINE_LEN - 12'h001);
    end
  end

  // black average of eight shielded pixels, white peak of the two pulses
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      black_sum     <= 11'h000;
      white_max     <= 8'h00;
      black_level_o <= 8'h00;
      white_level_o <= 8'h00;
    end else if (xfer_fall_ev) begin
      black_sum <= 11'h000;
      white_max <= 8'h00;
    end else if (capture && (state == ccdseq_pkg::SAMP_LINE)) begin
      if (cap_kind == ccdseq_pkg::KIND_BLACK) begin
        black_sum <= black_sum + {3'h0, vid_s2};
      end
      if ((cap_kind == ccdseq_pkg::KIND_WHITE) && (vid_s2 > white_max)) begin
        white_max <= vid_s2;
      end
      if (idx == `CCD_LINE_LEN - 12'h001) begin
        // the last pixel is a white one; fold it in here
        black_level_o <= black_sum[10:3];
        white_level_o <= (vid_s2 > white_max) ? vid_s2 : white_max;
      end
    end
  end

  // reset clock is 25 MHz / 4 = 6.25 MHz, under the 8 MHz ceiling
  // transfer falls at phase 6, two cycles clear of the transport rise at 0

endmodule : ccdseq_ctrl

// ---- ccdseq_link_properties.sv ----
module ccdseq_link_properties #(
  parameter int EXPO_TCK = 1800
) (
  // controller clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // link signals
  input wire logic       pixel_reset_clock,
  input wire logic       transport_clock,
  input wire logic       charge_transfer_pulse,
  input wire logic       white_ref_clock,
  input wire logic [7:0] video_output,
  input wire logic       end_of_scan_pulse
);
  timeunit 1ns;
  timeprecision 100ps;

  // short exposures are clamped, so the spacing never drops below the line length
  localparam int XFER_MCLK = 8 * ((EXPO_TCK < 1745) ? 1745 : EXPO_TCK);

  logic [15:0] gap;
  logic        armed;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // saturating count of cycles since the last transfer rise
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gap   <= 16'h0000;
      armed <= 1'b0;
    end else if ($rose(charge_transfer_pulse)) begin
      gap   <= 16'h0001;
      armed <= 1'b1;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end

  tck_toggle_a: assert property ($rose(transport_clock) |->
    transport_clock[*4] ##1 (!transport_clock)[*4] ##1 transport_clock)
    else $error("transport clock period wrong");
  pixclk_rate_a: assert property ($rose(pixel_reset_clock) |->
    ##1 !$rose(pixel_reset_clock) ##1 !$rose(pixel_reset_clock) ##1 !$rose(pixel_reset_clock))
    else $error("reset clock faster than allowed");
  pixclk_shape_a: assert property ($rose(pixel_reset_clock) |->
    pixel_reset_clock[*2] ##1 (!pixel_reset_clock)[*2] ##1 pixel_reset_clock)
    else $error("reset clock high time or period wrong");
  pixclk_phase_a: assert property ($rose(transport_clock) |->
    !pixel_reset_clock ##1 pixel_reset_clock)
    else $error("reset clock not one cycle after transport rise");
  xfer_rise_a: assert property ($rose(charge_transfer_pulse) |-> $rose(transport_clock))
    else $error("transfer rose away from transport rise");
  xfer_fall_a: assert property ($fell(transport_clock) && charge_transfer_pulse |->
    charge_transfer_pulse ##1 charge_transfer_pulse ##1 !charge_transfer_pulse)
    else $error("transfer fall not two cycles after transport fall");
  tck_after_xfer_a: assert property ($fell(charge_transfer_pulse) |->
    !transport_clock ##1 !transport_clock ##1 transport_clock)
    else $error("transport rise not two cycles after transfer fall");
  white_window_a: assert property ($fell(white_ref_clock) |->
    $rose(transport_clock) ##4 ($rose(white_ref_clock) && $fell(transport_clock)))
    else $error("white reference edges misplaced");
  white_xfer_a: assert property ($fell(white_ref_clock) |-> $rose(charge_transfer_pulse))
    else $error("white pulse without transfer");
  xfer_spacing_a: assert property ($rose(charge_transfer_pulse) && armed |->
    gap == XFER_MCLK && gap >= 4 * 3489)
    else $error("transfer spacing wrong");
  scan_end_white_a: assert property ($rose(end_of_scan_pulse) |->
    (end_of_scan_pulse && video_output == 8'hff)[*4] ##1 !end_of_scan_pulse)
    else $error("end of scan not with first white pixel");

  cover property ($fell(charge_transfer_pulse));
  cover property ($rose(end_of_scan_pulse));
  cover property ($rose(white_ref_clock));
endmodule : ccdseq_link_properties

// ---- ccdseq_tb.sv ----
module ccdseq_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [11:0]              idx;
    ccdseq_pkg::ccdseq_kind_t kind;
    logic [7:0]               data;
    logic                     scan_end;
    logic                     done;
  } ccdseq_exp_t;

  localparam int EXPO = 1800;

  logic                     mclk_i;
  logic                     rst_n_i;
  logic                     sens_rst_n;
  logic                     wr_enable_i;
  logic [7:0]               illum_i;
  logic                     pix_valid_o;
  logic [7:0]               pix_data_o;
  logic [11:0]              pix_index_o;
  ccdseq_pkg::ccdseq_kind_t pix_kind_o;
  logic                     line_start_o;
  logic                     line_done_o;
  logic                     scan_end_o;
  logic [7:0]               black_level_o;
  logic [7:0]               white_level_o;
  logic                     armed;
  logic [15:0]              lfsr;
  ccdseq_exp_t              notes[$];
  ccdseq_exp_t              e;
  int                       n_mismatch;
  int                       samples_checked;
  int                       cyc;
  int                       last_valid;

  ccdseq_link_if u_ccdseq_link_if ();

  ccdseq_ctrl #(.EXPO_TCK(EXPO)) u_ccdseq_ctrl (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_enable_i(wr_enable_i), .link(u_ccdseq_link_if),
    .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o), .pix_index_o(pix_index_o),
    .pix_kind_o(pix_kind_o), .line_start_o(line_start_o), .line_done_o(line_done_o),
    .scan_end_o(scan_end_o), .black_level_o(black_level_o), .white_level_o(white_level_o));

  ccdseq_sensor u_ccdseq_sensor (
    .link(u_ccdseq_link_if), .rst_n_i(sens_rst_n), .illum_i(illum_i));

  ccdseq_link_properties #(.EXPO_TCK(EXPO)) u_ccdseq_link_properties (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .pixel_reset_clock(u_ccdseq_link_if.pixel_reset_clock),
    .transport_clock(u_ccdseq_link_if.transport_clock),
    .charge_transfer_pulse(u_ccdseq_link_if.charge_transfer_pulse),
    .white_ref_clock(u_ccdseq_link_if.white_ref_clock),
    .video_output(u_ccdseq_link_if.video_output),
    .end_of_scan_pulse(u_ccdseq_link_if.end_of_scan_pulse));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic ccdseq_pkg::ccdseq_kind_t kind_of(input int i);
    if (i < 13 || (i > 3476 && i < 3487)) return ccdseq_pkg::KIND_EMPTY;
    if (i < 17 || (i > 3472 && i < 3477)) return ccdseq_pkg::KIND_BLACK;
    if (i < 3473) return ccdseq_pkg::KIND_IMAGE;
    return ccdseq_pkg::KIND_WHITE;
  endfunction : kind_of

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // one note per pixel of the coming line
  task automatic note_line(input logic [7:0] img, input logic we);
    ccdseq_exp_t x;
    for (int i = 0; i < 3489; i++) begin
      x.idx  = i[11:0];
      x.kind = kind_of(i);
      x.data = (x.kind == ccdseq_pkg::KIND_IMAGE) ? img :
               (x.kind == ccdseq_pkg::KIND_WHITE && we) ? 8'hff : 8'h00;
      x.scan_end = we && (i == 3487);
      x.done = (i == 3488);
      notes.push_back(x);
    end
  endtask : note_line

  task automatic wait_start();
    for (int k = 0; k < 20000 && line_start_o !== 1'b1; k++) @(negedge mclk_i);
    check("line start", 16'(line_start_o), 16'h0001);
    check("transfer low at start", 16'(u_ccdseq_link_if.charge_transfer_pulse), 16'h0000);
  endtask : wait_start

  // the sensor leaves reset early in the first exposure; the first line is only watched
  initial begin
    rst_n_i = 1'b0;
    sens_rst_n = 1'b0;
    wr_enable_i = 1'b1;
    illum_i = 8'h00;
    armed = 1'b0;
    lfsr = 16'h80f0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (20) @(negedge mclk_i);
    sens_rst_n = 1'b1;
    for (int n = 0; n < 4; n++) begin
      wait_start();
      if (n > 0) begin
        armed = 1'b1;
        note_line((n == 2) ? 8'hff : 8'h00, n != 2);
      end
      @(negedge mclk_i);
      if (n == 1) begin
        repeat (100) @(negedge mclk_i);
        lfsr = lfsr_next(lfsr);
        illum_i = lfsr[7:0] | 8'h80;
        repeat (6900) @(negedge mclk_i);
        illum_i = 8'h00;
        wr_enable_i = 1'b0;
      end
      if (n == 2) begin
        repeat (7000) @(negedge mclk_i);
        wr_enable_i = 1'b1;
      end
    end
    for (int k = 0; k < 20000 && notes.size() != 0; k++) @(negedge mclk_i);
    check("pending notes", 16'(notes.size()), 16'h0000);
    report_and_stop();
  end

  always @(negedge mclk_i) begin
    cyc++;
    if (pix_valid_o === 1'b1 && armed === 1'b1) begin
      if (notes.size() == 0) begin
        check("extra pixel", 16'h0001, 16'h0000);
      end else begin
        e = notes.pop_front();
        check("index", 16'(pix_index_o), 16'(e.idx));
        check("kind", 16'(pix_kind_o), 16'(e.kind));
        check("data", 16'(pix_data_o), 16'(e.data));
        check("end of scan", 16'(scan_end_o), 16'(e.scan_end));
        check("line done", 16'(line_done_o), 16'(e.done));
        if (e.idx != 12'h000) check("valid spacing", 16'(cyc - last_valid), 16'h0004);
        if (e.done) check("black level", 16'(black_level_o), 16'h0000);
        if (e.done) check("white level", 16'(white_level_o), 16'(e.data));
      end
      last_valid = cyc;
    end
  end

  // five exposures of 8*EXPO cycles plus reset and margin
  initial begin
    cyc = 0;
    last_valid = 0;
    repeat (5 * 8 * EXPO + 5000) @(posedge mclk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule : ccdseq_tb
